// ### inc/ebmcd_pkg.sv
`default_nettype none
package ebmcd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [29:0] IDX_CLK_DIV  = 30'h0000_1C26;
  localparam logic [29:0] IDX_LANE_CTL = 30'h0000_1C33;
  localparam logic [29:0] IDX_STATUS   = 30'h0000_1C34;

  localparam logic [31:0] ADDR_CLK_DIV  = {IDX_CLK_DIV, 2'b00};
  localparam logic [31:0] ADDR_LANE_CTL = {IDX_LANE_CTL, 2'b00};
  localparam logic [31:0] ADDR_STATUS   = {IDX_STATUS, 2'b00};

  // Field positions
  localparam int LANE_SEL_LSB  = 0;
  localparam int HALF_N_POS    = 0;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_BEAT_POS = 1;
  localparam int STAT_WID_LSB  = 2;

  // Values after reset
  localparam logic [1:0] LANE_SEL_RESET = 2'h0;
  localparam logic       HALF_N_RESET   = 1'h1;

  // Byte-lane select encodings
  localparam logic [1:0] LANE_WORD     = 2'h0;
  localparam logic [1:0] LANE_HIGH     = 2'h1;
  localparam logic [1:0] LANE_LOW      = 2'h2;
  localparam logic [1:0] LANE_RESERVED = 2'h3;

  // External bus width encodings
  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;

  // AHB-Lite
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [1:0] {
    EBMCD_IDLE,
    EBMCD_BEAT,
    EBMCD_DONE
  } ebmcd_state_e;

endpackage
`default_nettype wire

// ### src/ebmcd_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module ebmcd_clk_div (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic full_rate,
  output logic      clk_en
);

  typedef struct packed {
    logic phase;
    logic en;
  } ebmcd_div_s;

  ebmcd_div_s div_reg;
  ebmcd_div_s div_next;

  always_comb begin
    div_next = div_reg;
    if (full_rate) begin
      div_next.phase = 1'b0;
      div_next.en    = 1'b1;
    end else begin
      div_next.phase = ~div_reg.phase;
      div_next.en    = div_reg.phase;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign clk_en = div_reg.en;

endmodule // ebmcd_clk_div
`default_nettype wire

// ### src/ebmcd_top.sv
// Behaviour
// - Lane select governs data, program and register accesses of the CPU.
// - Lane select zero: full 16-bit word access, no masking.
// - Lane select one: byte access on upper byte, lower byte masked.
// - Lane select two: byte access on lower byte, upper byte masked.
// - Divider bit clear: interface enable runs at half the clock rate.
// - Divider bit set: full rate; bit resets to one.
// - Selected rate paces every external access, async and sync alike.
// - Word mode on 8-bit bus: two 8-bit external accesses per word; a register access takes one 16-bit access.
// - Upper-byte mode on 16-bit bus: one access on high lane only.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ebmcd_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // CPU word access port
  input  wire logic        cpu_req,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_reg_sel,
  input  wire logic        cpu_prog,
  input  wire logic [22:0] cpu_addr,
  input  wire logic [15:0] cpu_wdata,
  output logic             cpu_ready,
  output logic [15:0]      cpu_rdata,
  // Memory interface side
  input  wire logic [1:0]  external_bus_width,
  input  wire logic        mi_ack,
  input  wire logic [15:0] mi_rdata,
  output logic             mi_req,
  output logic             mi_wr,
  output logic             mi_reg_sel,
  output logic             mi_prog,
  output logic [23:0]      mi_addr,
  output logic [15:0]      mi_wdata,
  output logic [1:0]       mi_be,
  output logic             mi_narrow,
  output logic             mi_clk_en
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [1:0] lane_be(input logic [1:0] sel);
    case (sel)
      ebmcd_pkg::LANE_HIGH: lane_be = 2'h2;
      ebmcd_pkg::LANE_LOW:  lane_be = 2'h1;
      default:              lane_be = 2'h3;
    endcase
  endfunction

  function automatic logic [15:0] lane_mask(input logic [15:0] d, input logic [1:0] be);
    logic [15:0] m;
    m = '0;
    for (int i = 0; i < 2; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    lane_mask = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0]              lane_sel;
    logic                    half_rate_n;
    logic                    ph_write;
    logic                    ph_lane;
    logic                    ph_div;
    logic [31:0]             rd_data;
    ebmcd_pkg::ebmcd_state_e st;
    logic [15:0]             wdata;
    logic [1:0]              be;
    logic                    narrow;
    logic                    two_beat;
    logic                    beat_hi;
    logic [15:0]             rdata;
    logic                    req;
    logic                    wr;
    logic                    reg_sel;
    logic                    prog;
    logic [23:0]             addr;
    logic [15:0]             out_wdata;
    logic [1:0]              out_be;
  } ebmcd_state_s;

  ebmcd_state_s st_reg;
  ebmcd_state_s st_next;

  logic take;
  logic wdata_ok;

  assign take = hsel & hready & htrans[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next  = st_reg;
    wdata_ok = hwdata[1:0] != ebmcd_pkg::LANE_RESERVED;

    // Data phase of a write; reserved upper bits are dropped
    if (st_reg.ph_write && st_reg.ph_lane && wdata_ok) begin
      st_next.lane_sel = hwdata[ebmcd_pkg::LANE_SEL_LSB +: 2];
    end
    if (st_reg.ph_write && st_reg.ph_div) begin
      st_next.half_rate_n = hwdata[ebmcd_pkg::HALF_N_POS];
    end

    // Address phase
    st_next.ph_write = take & hwrite;
    st_next.ph_lane  = take && haddr == ebmcd_pkg::ADDR_LANE_CTL;
    st_next.ph_div   = take && haddr == ebmcd_pkg::ADDR_CLK_DIV;

    // Read data built from post-write values so back-to-back write/read agree
    if (take && !hwrite) begin
      st_next.rd_data = '0;
      if (haddr == ebmcd_pkg::ADDR_LANE_CTL) begin
        st_next.rd_data[ebmcd_pkg::LANE_SEL_LSB +: 2] = st_next.lane_sel;
      end else if (haddr == ebmcd_pkg::ADDR_CLK_DIV) begin
        st_next.rd_data[ebmcd_pkg::HALF_N_POS] = st_next.half_rate_n;
      end else if (haddr == ebmcd_pkg::ADDR_STATUS) begin
        st_next.rd_data[ebmcd_pkg::STAT_BUSY_POS]     = st_reg.st != ebmcd_pkg::EBMCD_IDLE;
        st_next.rd_data[ebmcd_pkg::STAT_BEAT_POS]     = st_reg.beat_hi;
        st_next.rd_data[ebmcd_pkg::STAT_WID_LSB +: 2] = external_bus_width;
      end
    end

    // CPU access sequencer
    case (st_reg.st)
      ebmcd_pkg::EBMCD_IDLE: begin
        if (cpu_req) begin
          st_next.wr       = cpu_wr;
          st_next.reg_sel  = cpu_reg_sel;
          st_next.prog     = cpu_prog;
          st_next.wdata    = cpu_wdata;
          st_next.be       = lane_be(st_reg.lane_sel);
          st_next.narrow   = !cpu_reg_sel && external_bus_width == ebmcd_pkg::WIDTH_8;
          st_next.two_beat = st_next.narrow && st_next.be == 2'h3;
          st_next.beat_hi  = st_next.narrow && st_next.be == 2'h2;
          st_next.rdata    = '0;
          st_next.req      = 1'b1;
          st_next.addr     = {cpu_addr, st_next.beat_hi};
          if (st_next.narrow) begin
            // Byte beat carries the chosen CPU byte on the low lane
            st_next.out_wdata = {8'h00, st_next.beat_hi ? cpu_wdata[15:8] : cpu_wdata[7:0]};
            st_next.out_be    = st_next.beat_hi ? 2'h2 : 2'h1;
          end else begin
            st_next.out_wdata = lane_mask(cpu_wdata, st_next.be);
            st_next.out_be    = st_next.be;
          end
          st_next.st = ebmcd_pkg::EBMCD_BEAT;
        end
      end
      ebmcd_pkg::EBMCD_BEAT: begin
        if (mi_ack) begin
          if (st_reg.narrow) begin
            if (st_reg.beat_hi) begin
              st_next.rdata[15:8] = mi_rdata[7:0];
            end else begin
              st_next.rdata[7:0] = mi_rdata[7:0];
            end
          end else begin
            st_next.rdata = lane_mask(mi_rdata, st_reg.be);
          end
          if (st_reg.two_beat && !st_reg.beat_hi) begin
            // Second byte of the word follows at the next byte address
            st_next.beat_hi   = 1'b1;
            st_next.addr[0]   = 1'b1;
            st_next.out_wdata = {8'h00, st_reg.wdata[15:8]};
            st_next.out_be    = 2'h2;
          end else begin
            st_next.req = 1'b0;
            st_next.st  = ebmcd_pkg::EBMCD_DONE;
          end
        end
      end
      ebmcd_pkg::EBMCD_DONE: begin
        st_next.st = ebmcd_pkg::EBMCD_IDLE;
      end
      default: begin
        st_next.req = 1'b0;
        st_next.st  = ebmcd_pkg::EBMCD_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg             <= '0;
      st_reg.lane_sel    <= ebmcd_pkg::LANE_SEL_RESET;
      st_reg.half_rate_n <= ebmcd_pkg::HALF_N_RESET;
      st_reg.st          <= ebmcd_pkg::EBMCD_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interface clock enable; the memory interface advances all its timing on it

  ebmcd_clk_div u_div (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .full_rate (st_reg.half_rate_n),
    .clk_en    (mi_clk_en)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout  = 1'b1;
  assign hresp      = ebmcd_pkg::HRESP_OKAY;
  assign hrdata     = st_reg.rd_data;
  assign cpu_ready  = st_reg.st == ebmcd_pkg::EBMCD_DONE;
  assign cpu_rdata  = st_reg.rdata;
  assign mi_req     = st_reg.req;
  assign mi_wr      = st_reg.wr;
  assign mi_reg_sel = st_reg.reg_sel;
  assign mi_prog    = st_reg.prog;
  assign mi_addr    = st_reg.addr;
  assign mi_wdata   = st_reg.out_wdata;
  assign mi_be      = st_reg.out_be;
  assign mi_narrow  = st_reg.narrow;

endmodule // ebmcd_top
`default_nettype wire

// ### test/ebmcd_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ebmcd_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        cpu_req,
  input wire logic        cpu_ready,
  input wire logic        mi_ack,
  input wire logic        mi_req,
  input wire logic [23:0] mi_addr,
  input wire logic [15:0] mi_wdata,
  input wire logic [1:0]  mi_be,
  input wire logic        mi_narrow,
  input wire logic        mi_clk_en
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  take_cause_a:
    assert property ($rose(mi_req) |-> $past(cpu_req)) else $error("beat without request");
  beat_hold_a:
    assert property (mi_req && !mi_ack |=> mi_req && $stable(mi_addr) && $stable(mi_wdata)
      && $stable(mi_be)) else $error("beat changed before ack");
  done_after_a:
    assert property (cpu_ready |-> $past(mi_ack) && !mi_req) else $error("done without ack");
  done_pulse_a:
    assert property (cpu_ready |=> !cpu_ready) else $error("done longer than one cycle");
  lane_any_a:
    assert property (mi_req |-> mi_be != 2'h0) else $error("beat with no lane");
  narrow_one_a:
    assert property (mi_req && mi_narrow |-> $onehot(mi_be) && mi_wdata[15:8] == 8'h00)
      else $error("narrow beat not one byte");
  low_mask_a:
    assert property (mi_req && !mi_narrow && !mi_be[0] |-> mi_wdata[7:0] == 8'h00)
      else $error("masked low byte driven");
  high_mask_a:
    assert property (mi_req && !mi_narrow && !mi_be[1] |-> mi_wdata[15:8] == 8'h00)
      else $error("masked high byte driven");
  rate_floor_a:
    assert property (!mi_clk_en |=> mi_clk_en) else $error("enable slower than half rate");
endmodule // ebmcd_chk
////////////////////////////////
bind ebmcd_top ebmcd_chk ebmcd_chk_inst (.hclk, .hresetn, .cpu_req, .cpu_ready, .mi_ack,
  .mi_req, .mi_addr, .mi_wdata, .mi_be, .mi_narrow, .mi_clk_en);
`default_nettype wire

// ### test/ebmcd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ebmcd_mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        mi_req,
  input  wire logic [2:0]  mi_kind,
  input  wire logic [23:0] mi_addr,
  input  wire logic [15:0] mi_wdata,
  input  wire logic [1:0]  mi_be,
  input  wire logic        mi_clk_en,
  input  wire logic [1:0]  dly,
  output logic             mi_ack,
  output logic [15:0]      mi_rdata,
  output int               nb,
  output logic [44:0]      lg
);
  logic [1:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mi_ack <= 1'b0;
      mi_rdata <= 16'h0000;
      cnt <= 2'h0;
      nb <= 0;
      lg <= '0;
    end else begin
      mi_ack <= 1'b0;
      // Released bus does not hold the last word; it inverts every cycle
      mi_rdata <= ~mi_rdata;
      // Own timing advances only on enabled cycles
      if (mi_req && !mi_ack && mi_clk_en) begin
        cnt <= cnt + 2'h1;
        if (cnt == dly) begin
          cnt <= 2'h0;
          mi_ack <= 1'b1;
          mi_rdata <= {mi_addr[8:1] ^ 8'h5A, mi_addr[8:1] ^ {7'h00, mi_addr[0]}};
          nb <= nb + 1;
          lg <= {mi_kind, mi_addr, mi_wdata, mi_be};
        end
      end
    end
  end
endmodule // ebmcd_mem_model
`default_nettype wire

// ### test/ebmcd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ebmcd_top_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        cpu_req = 1'b0, cpu_wr = 1'b0, cpu_reg_sel = 1'b0, cpu_prog = 1'b0;
  logic        hready, hreadyout, hresp, cpu_ready, mi_ack, mi_req, mi_wr;
  logic        mi_reg_sel, mi_prog, mi_narrow, mi_clk_en;
  logic [1:0]  htrans = 2'h0, ebw = 2'h0, dly = 2'h0, mi_be;
  logic [2:0]  hsize = 3'h2;
  logic [22:0] cpu_addr = 23'h000000;
  logic [15:0] cpu_wdata = 16'h0000, cpu_rdata, mi_rdata, mi_wdata;
  logic [23:0] mi_addr;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, s = 32'h0000E448;
  logic [44:0] lg;
  int          nb, err_total = 0, tests_run = 0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  ebmcd_top ebmcd_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .cpu_req, .cpu_wr, .cpu_reg_sel,
    .cpu_prog, .cpu_addr, .cpu_wdata, .cpu_ready, .cpu_rdata, .external_bus_width(ebw),
    .mi_ack, .mi_rdata, .mi_req, .mi_wr, .mi_reg_sel, .mi_prog, .mi_addr, .mi_wdata,
    .mi_be, .mi_narrow, .mi_clk_en);
  ebmcd_mem_model ebmcd_mem_model_inst (.hclk, .hresetn, .mi_req, .mi_addr, .mi_wdata,
    .mi_kind({mi_reg_sel, mi_prog, mi_wr}), .mi_be, .mi_clk_en, .dly, .mi_ack, .mi_rdata,
    .nb, .lg);
  ////////////////////////////////
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [15:0] rexp(input logic [1:0] l, input logic n,
                                       input logic [7:0] b);
    logic [7:0] hi;
    hi = n ? b ^ 8'h01 : b ^ 8'h5A;
    return {l == 2'h2 ? 8'h00 : hi, l == 2'h1 ? 8'h00 : b};
  endfunction
  function automatic logic [17:0] wexp(input logic [1:0] l, input logic n,
                                       input logic [15:0] d);
    logic [1:0] be;
    be = (l == 2'h2) ? 2'h1 : (l == 2'h1 || n) ? 2'h2 : 2'h3;
    if (n) return {8'h00, be[1] ? d[15:8] : d[7:0], be};
    return {be[1] ? d[15:8] : 8'h00, be[0] ? d[7:0] : 8'h00, be};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic cpu(input logic [2:0] k, input logic [22:0] a, input logic [15:0] d);
    cpu_req <= 1'b1;
    {cpu_prog, cpu_reg_sel, cpu_wr} <= k;
    cpu_addr <= a;
    cpu_wdata <= d;
    do @(posedge hclk); while (cpu_ready !== 1'b1);
    cpu_req <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic rate(input int e);
    int c;
    c = 0;
    repeat (2) @(posedge hclk);
    repeat (16) begin
      @(posedge hclk);
      if (mi_clk_en === 1'b1) c++;
    end
    chk("enable count", e, c);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////
  initial begin
    logic [31:0] r, k, a;
    logic [1:0]  ln;
    logic        nw;
    int          n0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, ebmcd_pkg::ADDR_LANE_CTL, 32'h0, r);
    chk("lane reset", 32'h0, r);
    ahb(1'b0, ebmcd_pkg::ADDR_CLK_DIV, 32'h0, r);
    chk("divider reset", 32'h1, r);
    ahb(1'b0, 32'h0000_0100, 32'h0, r);
    chk("unmapped read", 32'h0, r);
    ahb(1'b1, ebmcd_pkg::ADDR_LANE_CTL, 32'hFFFF_FFF1, r);
    ahb(1'b1, ebmcd_pkg::ADDR_LANE_CTL, 32'h3, r);
    chk("response", 32'h0, {31'h0, hresp});
    ahb(1'b0, ebmcd_pkg::ADDR_LANE_CTL, 32'h0, r);
    chk("lane reserved", 32'h1, r);
    $display("test registers done");
    rate(16);
    ahb(1'b1, ebmcd_pkg::ADDR_CLK_DIV, 32'h0, r);
    rate(8);
    $display("test clock rate done");
    repeat (80) begin
      ln = 2'(rnd() % 32'h3);
      ahb(1'b1, ebmcd_pkg::ADDR_LANE_CTL, {30'h0, ln}, r);
      ahb(1'b1, ebmcd_pkg::ADDR_CLK_DIV, rnd() & 32'h1, r);
      k = rnd();
      a = rnd();
      nw = !k[1] && !k[3];
      ebw <= {1'b0, k[3]};
      dly <= k[5:4];
      n0 = nb;
      cpu(k[2:0], a[22:0], a[31:16]);
      chk("beat count", (ln == 2'h0 && nw) ? 2 : 1, nb - n0);
      chk("beat kind", {k[1], k[2], k[0], a[22:0]}, lg[44:19]);
      if (k[0]) chk("write beat", wexp(ln, nw, a[31:16]), lg[17:0]);
      else chk("read word", rexp(ln, nw, a[7:0]), cpu_rdata);
      // Idle status: width as strapped, beat flag set if the last beat was a narrow high-byte beat
      ahb(1'b0, ebmcd_pkg::ADDR_STATUS, 32'h0, r);
      chk("status", {28'h0000000, ebw, nw && ln != 2'h2, 1'b0}, r);
    end
    $display("test random access done");
    // Mid-run reset must restore word mode and full rate
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, ebmcd_pkg::ADDR_LANE_CTL, 32'h0, r);
    chk("lane after reset", 32'h0, r);
    ahb(1'b0, ebmcd_pkg::ADDR_CLK_DIV, 32'h0, r);
    chk("divider after reset", 32'h1, r);
    rate(16);
    $display("test mid-run reset done");
    finish_test();
  end
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
endmodule // ebmcd_top_tb
`default_nettype wire
